/* File: inc/pcf_pkg.sv */
// Shared constants and types for the phase-locked clock fanout control block.
package pcf_pkg;

  // System clock rate and the documented lock acquisition times.
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TLOCK_MIN_MS = 1;
  localparam int unsigned TLOCK_MAX_MS = 10;
  localparam int unsigned TLOCK_MIN_CYC = TLOCK_MIN_MS * 1000 * CLK_MHZ;

  // Longest reference period and fastest double-rate output.
  localparam int unsigned REF_PERIOD_MAX_NS = 100;
  localparam int unsigned DBL_FMAX_MHZ = 100;
  localparam int unsigned REF_GAP_CYC_INT = (REF_PERIOD_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned HP_MIN_INT = (CLK_MHZ + 2 * DBL_FMAX_MHZ - 1) / (2 * DBL_FMAX_MHZ);

  // Consecutive aligned reference periods needed before lock is declared.
  localparam int unsigned LOCK_PERIODS = 32;

  // Oscillator model: half-period in system clocks.
  localparam int unsigned HP_W = 8;
  localparam logic [7:0] HP_MIN = HP_MIN_INT[7:0];
  localparam logic [7:0] HP_MAX = 8'hFF;
  localparam logic [7:0] HP_INIT = 8'h04;

  // Phase detector window and counter widths.
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] PH_TOL = 8'h02;
  localparam logic [7:0] CNT_SAT = 8'hFF;
  // Reference absent for twice the longest legal period counts as lost.
  localparam logic [7:0] REF_GAP_CYC = 8'(2 * REF_GAP_CYC_INT);

  // Output divider phase; all ones makes every divided output low except the inverted output, which is high.
  localparam logic [2:0] PHASE_RST = 3'h7;
  localparam logic [2:0] STEP_LOOP = 3'h1;
  localparam logic [2:0] STEP_BYPASS = 3'h2;

  // Bit positions in the synchronised pin vector.
  localparam int unsigned PIN_W = 8;
  localparam int unsigned PIN_A_TOG = 0;
  localparam int unsigned PIN_REF_A = 1;
  localparam int unsigned PIN_REF_B = 2;
  localparam int unsigned PIN_FB = 3;
  localparam int unsigned PIN_CHOICE = 4;
  localparam int unsigned PIN_DIV = 5;
  localparam int unsigned PIN_LOOP = 6;
  localparam int unsigned PIN_OE = 7;
  localparam logic [7:0] PIN_RST = 8'h00;

  typedef enum logic [1:0] {
    PCF_OFF,
    PCF_HOLD,
    PCF_RUN
  } pcf_state_t;

  typedef struct packed {
    logic [4:0] base_clock_outs;
    logic inverted_clock_out;
    logic double_rate_out;
    logic half_rate_out;
  } pcf_clk_out_t;

endpackage

/* File: src/pcf_lock_det.sv */
// Lock detector: declares lock after a settle time and a run of aligned reference periods.
`timescale 1ns/1ps
module pcf_lock_det #(
  parameter int unsigned MIN_CYC = pcf_pkg::TLOCK_MIN_CYC,
  parameter int unsigned LOCK_PERIODS = pcf_pkg::LOCK_PERIODS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic ref_evt_i,
  input wire logic aligned_i,
  input wire logic miss_i,
  output logic lock_o
);

  logic [31:0] tmr_q;
  logic [31:0] tmr_d;
  logic [15:0] run_q;
  logic [15:0] run_d;
  logic seen_q;
  logic seen_d;
  logic lock_q;
  logic lock_d;
  logic bad;

  always_comb
  begin
    bad = (ref_evt_i & ~aligned_i) | miss_i;
    tmr_d = tmr_q;
    run_d = run_q;
    seen_d = seen_q | ref_evt_i;
    if (!enable_i || miss_i)
    begin
      tmr_d = 32'h0000_0000;
      run_d = 16'h0000;
      seen_d = 1'b0;
    end
    else
    begin
      if (seen_q && tmr_q < MIN_CYC)
      begin
        tmr_d = tmr_q + 32'h0000_0001;
      end
      if (ref_evt_i)
      begin
        if (!aligned_i)
        begin
          run_d = 16'h0000;
        end
        else if (run_q < 16'(LOCK_PERIODS))
        begin
          run_d = run_q + 16'h0001;
        end
      end
    end
    lock_d = enable_i & ~bad & (tmr_d >= MIN_CYC) & (run_d >= 16'(LOCK_PERIODS));
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tmr_q <= 32'h0000_0000;
      run_q <= 16'h0000;
      seen_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else
    begin
      tmr_q <= tmr_d;
      run_q <= run_d;
      seen_q <= seen_d;
      lock_q <= lock_d;
    end
  end

  assign lock_o = lock_q;

endmodule // pcf_lock_det

/* File: src/pcf_top.sv */
// Phase-locked clock fanout control: pin conditioning, oscillator model and output dividers.
`timescale 1ns/1ps
module pcf_top #(
  parameter int unsigned LOCK_MIN_CYC = pcf_pkg::TLOCK_MIN_CYC,
  parameter int unsigned LOCK_PERIODS = pcf_pkg::LOCK_PERIODS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ref_a_clk_i,
  input wire logic ref_b_i,
  input wire logic ref_choice_i,
  input wire logic div_sel_i,
  input wire logic feedback_i,
  input wire logic loop_en_i,
  input wire logic oe_rst_n_i,
  output pcf_pkg::pcf_clk_out_t clk_out_o,
  output logic clk_oe_n_o,
  output logic lock_o
);

  // Link domain: one toggle per rising edge of the first reference.
  logic a_tog_q;
  logic a_tog_d;

  always_comb
  begin
    a_tog_d = ~a_tog_q;
  end

  always_ff @(posedge ref_a_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      a_tog_q <= 1'b0;
    end
    else
    begin
      a_tog_q <= a_tog_d;
    end
  end

  // Every pin and the link toggle pass two flip-flops; prev_q feeds edge detection.
  logic [pcf_pkg::PIN_W-1:0] pin_raw;
  logic [pcf_pkg::PIN_W-1:0] meta_q;
  logic [pcf_pkg::PIN_W-1:0] pin_q;
  logic [pcf_pkg::PIN_W-1:0] prev_q;

  assign pin_raw = {oe_rst_n_i, loop_en_i, div_sel_i, ref_choice_i,
                    feedback_i, ref_b_i, ref_a_clk_i, a_tog_q};

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= pcf_pkg::PIN_RST;
      pin_q <= pcf_pkg::PIN_RST;
      prev_q <= pcf_pkg::PIN_RST;
    end
    else
    begin
      meta_q <= pin_raw;
      pin_q <= meta_q;
      prev_q <= pin_q;
    end
  end

  logic oe_on;
  logic loop_on;
  logic ref_lvl;
  logic ref_lvl_prev;
  logic ref_rise;
  logic ref_fall;
  logic fb_rise;

  always_comb
  begin
    oe_on = pin_q[pcf_pkg::PIN_OE];
    loop_on = pin_q[pcf_pkg::PIN_LOOP];
    if (pin_q[pcf_pkg::PIN_CHOICE])
    begin
      ref_lvl = pin_q[pcf_pkg::PIN_REF_B];
      ref_lvl_prev = prev_q[pcf_pkg::PIN_REF_B];
      ref_rise = pin_q[pcf_pkg::PIN_REF_B] & ~prev_q[pcf_pkg::PIN_REF_B];
    end
    else
    begin
      ref_lvl = pin_q[pcf_pkg::PIN_REF_A];
      ref_lvl_prev = prev_q[pcf_pkg::PIN_REF_A];
      ref_rise = pin_q[pcf_pkg::PIN_A_TOG] ^ prev_q[pcf_pkg::PIN_A_TOG];
    end
    ref_fall = ref_lvl_prev & ~ref_lvl;
    fb_rise = pin_q[pcf_pkg::PIN_FB] & ~prev_q[pcf_pkg::PIN_FB];
  end

  // Oscillator model and phase detector.
  logic [pcf_pkg::HP_W-1:0] hp_q;
  logic [pcf_pkg::HP_W-1:0] hp_d;
  logic [pcf_pkg::HP_W-1:0] vcnt_q;
  logic [pcf_pkg::HP_W-1:0] vcnt_d;
  logic div_q;
  logic div_d;
  logic [pcf_pkg::CNT_W-1:0] since_fb_q;
  logic [pcf_pkg::CNT_W-1:0] since_fb_d;
  logic [pcf_pkg::CNT_W-1:0] ref_per_q;
  logic [pcf_pkg::CNT_W-1:0] ref_per_d;
  logic [1:0] fb_cnt_q;
  logic [1:0] fb_cnt_d;
  // Bit 0 holds the oscillator back one clock, bit 1 pushes it one clock ahead.
  logic [1:0] slip_q;
  logic [1:0] slip_d;
  logic vco_tick;
  logic dist_tick;
  logic track;
  logic aligned;
  logic miss;
  logic [2:0] fb_n;
  logic [pcf_pkg::CNT_W-1:0] since_eff;
  logic [pcf_pkg::CNT_W:0] late_sum;

  always_comb
  begin
    hp_d = hp_q;
    vcnt_d = vcnt_q;
    div_d = div_q;
    vco_tick = 1'b0;
    // loop broken while outputs are off
    track = loop_on & oe_on;
    if (loop_on)
    begin
      if (slip_q[0])
      begin
        vcnt_d = vcnt_q;
      end
      else if (vcnt_q >= hp_q - 8'h01)
      begin
        vcnt_d = {7'h00, slip_q[1]};
        vco_tick = 1'b1;
      end
      else if (slip_q[1] && vcnt_q >= hp_q - 8'h02)
      begin
        vcnt_d = 8'h00;
        vco_tick = 1'b1;
      end
      else
      begin
        vcnt_d = vcnt_q + {6'h00, slip_q[1], ~slip_q[1]};
      end
    end
    else
    begin
      vcnt_d = 8'h00;
      div_d = 1'b0;
    end
    dist_tick = vco_tick & (pin_q[pcf_pkg::PIN_DIV] | div_q);
    if (vco_tick && !pin_q[pcf_pkg::PIN_DIV])
    begin
      div_d = ~div_q;
    end
    since_eff = fb_rise ? 8'h00 : since_fb_q;
    since_fb_d = since_eff;
    if (!fb_rise && since_fb_q != pcf_pkg::CNT_SAT)
    begin
      since_fb_d = since_fb_q + 8'h01;
    end
    ref_per_d = ref_per_q;
    if (ref_rise)
    begin
      ref_per_d = 8'h00;
    end
    else if (ref_per_q != pcf_pkg::CNT_SAT)
    begin
      ref_per_d = ref_per_q + 8'h01;
    end
    fb_n = {1'b0, fb_cnt_q} + {2'b00, fb_rise};
    fb_cnt_d = fb_cnt_q;
    if (ref_rise)
    begin
      fb_cnt_d = 2'h0;
    end
    else if (fb_rise && fb_cnt_q != 2'h3)
    begin
      fb_cnt_d = fb_cnt_q + 2'h1;
    end
    late_sum = {1'b0, since_eff} + {1'b0, pcf_pkg::PH_TOL};
    aligned = (fb_n == 3'h1) &&
              (since_eff <= pcf_pkg::PH_TOL || late_sum >= {1'b0, ref_per_q});
    miss = track & (ref_per_q == pcf_pkg::REF_GAP_CYC);
    // steer oscillator toward alignment
    // One feedback rise per period means the rate is right; only its phase is slipped, since
    // stepping the half-period there would keep the edge drifting through the window.
    slip_d = 2'b00;
    if (track && ref_rise && !aligned)
    begin
      // the feedback wiring fixes the ratio
      if (fb_n == 3'h0)
      begin
        // half-period floor keeps 100 MHz reachable
        if (hp_q > pcf_pkg::HP_MIN)
        begin
          hp_d = hp_q - 8'h01;
        end
      end
      else if (fb_n != 3'h1)
      begin
        if (hp_q < pcf_pkg::HP_MAX)
        begin
          hp_d = hp_q + 8'h01;
        end
      end
      else if (since_eff >= (ref_per_q >> 1))
      begin
        slip_d = 2'b10;
      end
      else
      begin
        slip_d = 2'b01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hp_q <= pcf_pkg::HP_INIT;
      vcnt_q <= 8'h00;
      div_q <= 1'b0;
      since_fb_q <= pcf_pkg::CNT_SAT;
      ref_per_q <= 8'h00;
      fb_cnt_q <= 2'h0;
      slip_q <= 2'b00;
    end
    else
    begin
      hp_q <= hp_d;
      vcnt_q <= vcnt_d;
      div_q <= div_d;
      since_fb_q <= since_fb_d;
      ref_per_q <= ref_per_d;
      fb_cnt_q <= fb_cnt_d;
      slip_q <= slip_d;
    end
  end

  // Output distribution and enable/reset sequencing.
  pcf_pkg::pcf_state_t st_q;
  pcf_pkg::pcf_state_t st_d;
  logic [2:0] phase_q;
  logic [2:0] phase_d;
  logic tick;
  logic [2:0] step;
  pcf_pkg::pcf_clk_out_t out_q;
  pcf_pkg::pcf_clk_out_t out_d;
  logic oe_n_q;
  logic oe_n_d;

  always_comb
  begin
    tick = loop_on ? dist_tick : ref_fall;
    step = loop_on ? pcf_pkg::STEP_LOOP : pcf_pkg::STEP_BYPASS;
    st_d = st_q;
    phase_d = phase_q;
    unique case (st_q)
      pcf_pkg::PCF_OFF:
      begin
        phase_d = pcf_pkg::PHASE_RST;
        if (oe_on)
        begin
          st_d = pcf_pkg::PCF_HOLD;
        end
      end
      pcf_pkg::PCF_HOLD:
      begin
        if (!oe_on)
        begin
          st_d = pcf_pkg::PCF_OFF;
        end
        // held low until a distributed oscillator tick
        // released by a falling edge in test mode
        else if (tick)
        begin
          st_d = pcf_pkg::PCF_RUN;
          phase_d = phase_q + step;
        end
      end
      pcf_pkg::PCF_RUN:
      begin
        if (!oe_on)
        begin
          st_d = pcf_pkg::PCF_OFF;
          phase_d = pcf_pkg::PHASE_RST;
        end
        else if (tick)
        begin
          phase_d = phase_q + step;
        end
      end
    endcase
    oe_n_d = (st_d == pcf_pkg::PCF_OFF);
    out_d.base_clock_outs = {5{~phase_d[1]}};
    out_d.half_rate_out = ~phase_d[2];
    out_d.inverted_clock_out = phase_d[1];
    out_d.double_rate_out = ~phase_d[0];
    // low hold, double-rate follows inverted reference
    if (st_d != pcf_pkg::PCF_RUN)
    begin
      out_d.base_clock_outs = 5'h00;
      out_d.half_rate_out = 1'b0;
      out_d.inverted_clock_out = 1'b0;
    end
    if (st_d != pcf_pkg::PCF_RUN || !loop_on)
    begin
      out_d.double_rate_out = ~ref_lvl;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= pcf_pkg::PCF_OFF;
      phase_q <= pcf_pkg::PHASE_RST;
      out_q <= '0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      phase_q <= phase_d;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign clk_out_o = out_q;
  assign clk_oe_n_o = oe_n_q;

  // lock follows loop-enable and outputs on
  pcf_lock_det #(
    .MIN_CYC(LOCK_MIN_CYC),
    .LOCK_PERIODS(LOCK_PERIODS)
  ) u_lock (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(track),
    .ref_evt_i(ref_rise),
    .aligned_i(aligned),
    .miss_i(miss),
    .lock_o(lock_o)
  );

endmodule // pcf_top

/* File: sim/pcf_monitor.sv */
// Port checker for the clock fanout control block, bound into its top.
`timescale 1ns/1ps
module pcf_monitor #(
  parameter int unsigned LOCK_MIN_CYC = 200,
  parameter int unsigned LOCK_PERIODS = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ref_a_clk_i,
  input wire logic ref_b_i,
  input wire logic ref_choice_i,
  input wire logic div_sel_i,
  input wire logic feedback_i,
  input wire logic loop_en_i,
  input wire logic oe_rst_n_i,
  input wire pcf_pkg::pcf_clk_out_t clk_out_o,
  input wire logic clk_oe_n_o,
  input wire logic lock_o
);
  logic [31:0] en_cyc_q;
  logic [31:0] en_cyc_d;
  logic tmode;
  // Counts raw enable time, which is never shorter than what the lock logic sees.
  always_comb
  begin
    en_cyc_d = (loop_en_i && oe_rst_n_i) ? en_cyc_q + 32'h1 : 32'h0;
    tmode = !loop_en_i && ref_choice_i && !clk_oe_n_o;
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      en_cyc_q <= 32'h0;
    else
      en_cyc_q <= en_cyc_d;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_base_same: assert property (clk_out_o.base_clock_outs inside {5'h00, 5'h1F})
    else $error("base outputs differ");
  a_oe_hiz: assert property (!oe_rst_n_i [*5] |-> clk_oe_n_o)
    else $error("outputs driven while disabled");
  a_hold_low: assert property ($fell(clk_oe_n_o) |-> (clk_out_o & 8'hFD) == 8'h00)
    else $error("outputs not low at release");
  a_dbl_ref: assert property (tmode [*6] |-> clk_out_o.double_rate_out == !$past(ref_b_i, 3))
    else $error("double rate not inverse reference");
  a_fall_step: assert property (tmode [*6] ##0 $changed(clk_out_o.base_clock_outs[0])
    |-> !$past(ref_b_i, 2)) else $error("base moved without falling reference");
  a_lock_loop: assert property (!loop_en_i [*5] |-> !lock_o)
    else $error("lock high with loop off");
  a_lock_oe: assert property (!oe_rst_n_i [*5] |-> !lock_o)
    else $error("lock high while disabled");
  a_lock_min: assert property ($rose(lock_o) |-> en_cyc_q >= LOCK_MIN_CYC)
    else $error("lock too early");
  c_lock: cover property ($rose(lock_o));
  c_release: cover property ($fell(clk_oe_n_o));
  c_step: cover property (tmode && $rose(clk_out_o.half_rate_out));
endmodule // pcf_monitor

bind pcf_top pcf_monitor #(.LOCK_MIN_CYC(LOCK_MIN_CYC), .LOCK_PERIODS(LOCK_PERIODS)) u_mon (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ref_a_clk_i(ref_a_clk_i), .ref_b_i(ref_b_i),
  .ref_choice_i(ref_choice_i), .div_sel_i(div_sel_i), .feedback_i(feedback_i),
  .loop_en_i(loop_en_i), .oe_rst_n_i(oe_rst_n_i), .clk_out_o(clk_out_o),
  .clk_oe_n_o(clk_oe_n_o), .lock_o(lock_o));

/* File: sim/pcf_board.sv */
// Board model: first reference clock source and the feedback wire.
`timescale 1ns/1ps
module pcf_board (
  input wire logic run_i,
  input wire logic [1:0] fb_sel_i,
  input wire pcf_pkg::pcf_clk_out_t clk_out_i,
  input wire logic clk_oe_n_i,
  output logic ref_a_clk_o,
  output logic feedback_o
);
  // period under 100 ns.
  // The start offset keeps every edge clear of the system clock edges.
  initial
  begin
    ref_a_clk_o = 1'b0;
    forever
    begin
      wait (run_i);
      #1.3;
      while (run_i)
      begin
        #7.5 ref_a_clk_o = 1'b1;
        #7.5 ref_a_clk_o = 1'b0;
      end
    end
  end
  // routed output feeds back.
  // A pull-down holds the pin low while the fed-back output floats.
  always_comb
  begin
    case (fb_sel_i)
      2'h0: feedback_o = clk_out_i.double_rate_out;
      2'h1: feedback_o = clk_out_i.base_clock_outs[4];
      default: feedback_o = clk_out_i.half_rate_out;
    endcase
    if (clk_oe_n_i)
      feedback_o = 1'b0;
  end
endmodule // pcf_board

/* File: sim/pcf_top_bench.sv */
// Self-checking bench for the clock fanout control block.
`timescale 1ns/1ps
module pcf_top_bench;
  typedef struct {
    logic choice;
    int falls;
    logic [7:0] base_r;
    logic [7:0] half_r;
    logic [7:0] inv_r;
  } pcf_row_t;
  pcf_row_t rows [3] = '{'{1'b0, 20, 8'h0A, 8'h05, 8'h0A}, '{1'b1, 8, 8'h04, 8'h02, 8'h04},
    '{1'b1, 1, 8'h01, 8'h01, 8'h00}};
  logic clk_i, rst_n_i, ref_b_i, ref_choice_i, div_sel_i, loop_en_i, oe_rst_n_i, run_a;
  logic ref_a_clk, feedback, clk_oe_n, lock;
  logic [1:0] fb_sel;
  logic [7:0] n_base, n_half, n_inv, n_dbl;
  pcf_pkg::pcf_clk_out_t clk_out, last;
  int n_fail, cmp_count, cyc, rb_half, rb_left, rb_cnt;
  pcf_top #(.LOCK_MIN_CYC(200), .LOCK_PERIODS(4)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ref_a_clk_i(ref_a_clk), .ref_b_i(ref_b_i),
    .ref_choice_i(ref_choice_i), .div_sel_i(div_sel_i), .feedback_i(feedback),
    .loop_en_i(loop_en_i), .oe_rst_n_i(oe_rst_n_i), .clk_out_o(clk_out),
    .clk_oe_n_o(clk_oe_n), .lock_o(lock));
  pcf_board board (.run_i(run_a), .fb_sel_i(fb_sel), .clk_out_i(clk_out),
    .clk_oe_n_i(clk_oe_n), .ref_a_clk_o(ref_a_clk), .feedback_o(feedback));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Rise counters are cleared once at start and then only count up; tests take differences so no test writes them.
  always @(posedge clk_i)
  begin
    last <= clk_out;
    n_base <= n_base + 8'(clk_out.base_clock_outs[0] && !last.base_clock_outs[0]);
    n_half <= n_half + 8'(clk_out.half_rate_out && !last.half_rate_out);
    n_inv <= n_inv + 8'(clk_out.inverted_clock_out && !last.inverted_clock_out);
    n_dbl <= n_dbl + 8'(clk_out.double_rate_out && !last.double_rate_out);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  always @(negedge clk_i)
  begin
    if (rb_left > 0)
    begin
      rb_cnt = rb_cnt + 1;
      if (rb_cnt >= rb_half)
      begin
        rb_cnt = 0;
        ref_b_i = !ref_b_i;
        if (!ref_b_i)
          rb_left = rb_left - 1;
      end
    end
  end
  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Edge counts over a window may land one off where an edge meets the window boundary.
  function automatic logic [7:0] near(input logic [7:0] exp, input logic [7:0] got);
    return (got == exp + 8'h01 || got + 8'h01 == exp) ? exp : got;
  endfunction
  task automatic wait_lock;
    int k = 0;
    while (lock !== 1'b1 && k < 3000)
    begin
      @(negedge clk_i);
      k++;
    end
  endtask
  task automatic run_row(input pcf_row_t r);
    logic [7:0] b0, h0, i0, d0;
    oe_rst_n_i = 1'b0;
    ref_choice_i = r.choice;
    repeat (8) @(negedge clk_i);
    cmp("oe_n_off", 8'h01, clk_oe_n);
    oe_rst_n_i = 1'b1;
    repeat (12) @(negedge clk_i);
    cmp("oe_n_on", 8'h00, clk_oe_n);
    cmp("hold", 8'h02, clk_out);
    {b0, h0, i0, d0} = {n_base, n_half, n_inv, n_dbl};
    if (r.choice)
    begin
      rb_half = 3;
      rb_left = r.falls;
      wait (rb_left == 0);
    end
    else
    begin
      run_a = 1'b1;
      #(15.0 * r.falls);
      run_a = 1'b0;
    end
    repeat (10) @(negedge clk_i);
    cmp("base_rises", r.base_r, n_base - b0);
    cmp("half_rises", r.half_r, n_half - h0);
    cmp("inv_rises", r.inv_r, n_inv - i0);
    cmp("dbl_rises", 8'(r.falls), n_dbl - d0);
    $display("test mode row done, choice %0d", r.choice);
  endtask
  task automatic lock_case(input logic [1:0] fb, input logic div, input logic [7:0] exp);
    logic [7:0] b0;
    fb_sel = fb;
    div_sel_i = div;
    loop_en_i = 1'b1;
    wait_lock();
    cmp("lock", 8'h01, lock);
    @(posedge ref_b_i);
    @(negedge clk_i);
    b0 = n_base;
    repeat (160) @(negedge clk_i);
    cmp("base_rate", exp, near(exp, n_base - b0));
    loop_en_i = 1'b0;
    repeat (6) @(negedge clk_i);
    cmp("lock_off", 8'h00, lock);
    $display("lock case done, feedback %0d", fb);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    {rst_n_i, ref_b_i, ref_choice_i, loop_en_i, run_a, fb_sel} = 7'h00;
    {div_sel_i, oe_rst_n_i} = 2'h3;
    {n_base, n_half, n_inv, n_dbl, last} = 40'h0;
    repeat (2) @(negedge clk_i);
    cmp("rst_out", 8'h00, clk_out);
    cmp("rst_oe", 8'h01, clk_oe_n);
    cmp("rst_lock", 8'h00, lock);
    rst_n_i = 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    ref_choice_i = 1'b1;
    rb_half = 8;
    rb_left = 100000;
    lock_case(2'h0, 1'b1, 8'h05);
    lock_case(2'h1, 1'b0, 8'h0A);
    lock_case(2'h2, 1'b1, 8'h14);
    loop_en_i = 1'b1;
    wait_lock();
    cmp("lock_pre", 8'h01, lock);
    oe_rst_n_i = 1'b0;
    repeat (6) @(negedge clk_i);
    cmp("oe_lock", 8'h00, lock);
    oe_rst_n_i = 1'b1;
    wait_lock();
    cmp("relock", 8'h01, lock);
    $display("relock test done");
    rst_n_i = 1'b0;
    @(negedge clk_i);
    cmp("rerst_out", 8'h00, clk_out);
    cmp("rerst_oe", 8'h01, clk_oe_n);
    cmp("rerst_lock", 8'h00, lock);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    cmp("rerst_oe_on", 8'h00, clk_oe_n);
    cmp("rerst_hold", 8'h00, clk_out & 8'hFD);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule // pcf_top_bench
